//--- rtl/bidir_port_pair_with_bus_mux.sv
// two bidirectional gpio ports, the second shared with the system bus
//
// Chosen here: the placing of the registers and the strobed register port.
module bidir_port_pair_with_bus_mux (
  input  wire logic       ref_clk_i,
  input  wire logic       rst_i,
  input  wire logic [3:0] addr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  output logic      [7:0] rdata_o,
  input  wire logic [7:0] p1_periph_en_i,
  input  wire logic [7:0] p1_periph_out_i,
  input  wire logic [7:0] p1_periph_oe_i,
  input  wire logic [7:0] p1_pad_i,
  output logic      [7:0] p1_pad_o,
  output logic      [7:0] p1_pad_oe_o,
  input  wire logic [7:0] p2_periph_en_i,
  input  wire logic [7:0] p2_periph_out_i,
  input  wire logic [7:0] p2_periph_oe_i,
  input  wire logic [7:0] bus_hi_out_i,
  input  wire logic       bus_hi_oe_i,
  input  wire logic [7:0] p2_pad_i,
  output logic      [7:0] p2_pad_o,
  output logic      [7:0] p2_pad_oe_o,
  output logic      [7:0] bus_hi_in_o,
  output logic            bus_disable_o
);
  logic [7:0] p1_dir_reg;
  logic [7:0] p1_dir_next;
  logic [7:0] p1_lat_reg;
  logic [7:0] p1_lat_next;
  logic [7:0] p2_dir_reg;
  logic [7:0] p2_dir_next;
  logic [7:0] p2_lat_reg;
  logic [7:0] p2_lat_next;
  logic [7:0] mem_ctl_reg;
  logic [7:0] mem_ctl_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic [7:0] p1_pin_val;
  logic [7:0] p2_pin_val;
  logic       bus_dis;
  logic [7:0] p2_ovr_en;
  logic [7:0] p2_ovr_out;
  logic [7:0] p2_ovr_oe;

  assign bus_dis = mem_ctl_reg[gpio_pkg::BUS_DIS_BIT];

  // bus mode takes the whole second port; gpio mode lets peripherals override
  always_comb begin
    if (bus_dis) begin
      p2_ovr_en  = p2_periph_en_i;
      p2_ovr_out = p2_periph_out_i;
      p2_ovr_oe  = p2_periph_oe_i;
    end else begin
      p2_ovr_en  = 8'hFF;
      p2_ovr_out = bus_hi_out_i;
      p2_ovr_oe  = {8{bus_hi_oe_i}};
    end
  end

  gpio_pin_stage u_p1 (
    .ref_clk_i (ref_clk_i),
    .rst_i     (rst_i),
    .dir_i     (p1_dir_reg),
    .lat_i     (p1_lat_reg),
    .ovr_en_i  (p1_periph_en_i),
    .ovr_out_i (p1_periph_out_i),
    .ovr_oe_i  (p1_periph_oe_i),
    .pad_i     (p1_pad_i),
    .pad_o     (p1_pad_o),
    .pad_oe_o  (p1_pad_oe_o),
    .pin_val_o (p1_pin_val)
  );

  gpio_pin_stage u_p2 (
    .ref_clk_i (ref_clk_i),
    .rst_i     (rst_i),
    .dir_i     (p2_dir_reg),
    .lat_i     (p2_lat_reg),
    .ovr_en_i  (p2_ovr_en),
    .ovr_out_i (p2_ovr_out),
    .ovr_oe_i  (p2_ovr_oe),
    .pad_i     (p2_pad_i),
    .pad_o     (p2_pad_o),
    .pad_oe_o  (p2_pad_oe_o),
    .pin_val_o (p2_pin_val)
  );

  // register writes; overrides never feed the direction registers
  always_comb begin
    p1_dir_next  = p1_dir_reg;
    p1_lat_next  = p1_lat_reg;
    p2_dir_next  = p2_dir_reg;
    p2_lat_next  = p2_lat_reg;
    mem_ctl_next = mem_ctl_reg;
    if (wr_i) begin
      if (addr_i == gpio_pkg::ADDR_P1_DIR) begin
        p1_dir_next = wdata_i;
      end else if (addr_i == gpio_pkg::ADDR_P1_LAT || addr_i == gpio_pkg::ADDR_P1_PIN) begin
        p1_lat_next = wdata_i;
      end else if (addr_i == gpio_pkg::ADDR_P2_DIR) begin
        p2_dir_next = wdata_i;
      end else if (addr_i == gpio_pkg::ADDR_P2_LAT || addr_i == gpio_pkg::ADDR_P2_PIN) begin
        p2_lat_next = wdata_i;
      end else if (addr_i == gpio_pkg::ADDR_MEM_CTL) begin
        mem_ctl_next = wdata_i & (8'h01 << gpio_pkg::BUS_DIS_BIT);
      end
    end
  end

  // read data stands in the cycle after the strobe only
  always_comb begin
    rdata_next = gpio_pkg::RD_ZERO;
    if (rd_i) begin
      if (addr_i == gpio_pkg::ADDR_P1_PIN) begin
        rdata_next = p1_pin_val;
      end else if (addr_i == gpio_pkg::ADDR_P1_DIR) begin
        rdata_next = p1_dir_reg;
      end else if (addr_i == gpio_pkg::ADDR_P1_LAT) begin
        rdata_next = p1_lat_reg;
      end else if (addr_i == gpio_pkg::ADDR_P2_PIN) begin
        rdata_next = p2_pin_val;
      end else if (addr_i == gpio_pkg::ADDR_P2_DIR) begin
        rdata_next = p2_dir_reg;
      end else if (addr_i == gpio_pkg::ADDR_P2_LAT) begin
        rdata_next = p2_lat_reg;
      end else if (addr_i == gpio_pkg::ADDR_MEM_CTL) begin
        rdata_next = mem_ctl_reg;
      end
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      p1_dir_reg  <= gpio_pkg::DIR_RST;
      p1_lat_reg  <= gpio_pkg::LAT_RST;
      p2_dir_reg  <= gpio_pkg::DIR_RST;
      p2_lat_reg  <= gpio_pkg::LAT_RST;
      mem_ctl_reg <= gpio_pkg::MEM_CTL_RST;
      rdata_reg   <= gpio_pkg::RD_ZERO;
    end else begin
      p1_dir_reg  <= p1_dir_next;
      p1_lat_reg  <= p1_lat_next;
      p2_dir_reg  <= p2_dir_next;
      p2_lat_reg  <= p2_lat_next;
      mem_ctl_reg <= mem_ctl_next;
      rdata_reg   <= rdata_next;
    end
  end

  assign rdata_o       = rdata_reg;
  assign bus_hi_in_o   = p2_pin_val;
  assign bus_disable_o = mem_ctl_reg[gpio_pkg::BUS_DIS_BIT];
endmodule : bidir_port_pair_with_bus_mux

//--- rtl/gpio_pin_stage.sv
// one 8-bit port pin stage: direction resolve and pad drive
module gpio_pin_stage (
  input  wire logic       ref_clk_i,
  input  wire logic       rst_i,
  input  wire logic [7:0] dir_i,
  input  wire logic [7:0] lat_i,
  input  wire logic [7:0] ovr_en_i,
  input  wire logic [7:0] ovr_out_i,
  input  wire logic [7:0] ovr_oe_i,
  input  wire logic [7:0] pad_i,
  output logic      [7:0] pad_o,
  output logic      [7:0] pad_oe_o,
  output logic      [7:0] pin_val_o
);
  logic [7:0] out_reg;
  logic [7:0] out_next;
  logic [7:0] oe_reg;
  logic [7:0] oe_next;
  logic [7:0] pin_reg;
  logic [7:0] pin_next;

  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (ovr_en_i[i]) begin
        oe_next[i]  = ovr_oe_i[i];
        out_next[i] = ovr_out_i[i];
      end else begin
        oe_next[i]  = ~dir_i[i];
        out_next[i] = lat_i[i];
      end
    end
    pin_next = pad_i;
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      out_reg <= 8'h00;
      oe_reg  <= 8'h00;
      pin_reg <= 8'h00;
    end else begin
      out_reg <= out_next;
      oe_reg  <= oe_next;
      pin_reg <= pin_next;
    end
  end

  assign pad_o     = out_reg;
  assign pad_oe_o  = oe_reg;
  assign pin_val_o = pin_reg;
endmodule : gpio_pin_stage

//--- rtl/gpio_pkg.sv
// constants for the two-port gpio block
package gpio_pkg;
  localparam int unsigned PORT_W = 8;
  localparam int unsigned ADDR_W = 4;
  // register addresses
  localparam logic [3:0] ADDR_P1_PIN  = 4'h0;
  localparam logic [3:0] ADDR_P1_DIR  = 4'h1;
  localparam logic [3:0] ADDR_P1_LAT  = 4'h2;
  localparam logic [3:0] ADDR_P2_PIN  = 4'h4;
  localparam logic [3:0] ADDR_P2_DIR  = 4'h5;
  localparam logic [3:0] ADDR_P2_LAT  = 4'h6;
  localparam logic [3:0] ADDR_MEM_CTL = 4'h8;
  // memory control field position
  localparam int unsigned BUS_DIS_BIT = 7;
  // reset values
  localparam logic [7:0] DIR_RST     = 8'hFF;
  localparam logic [7:0] LAT_RST     = 8'h00;
  localparam logic [7:0] MEM_CTL_RST = 8'h00;
  localparam logic [7:0] RD_ZERO     = 8'h00;
endpackage : gpio_pkg

//--- tb/gpio_monitor.sv
// assertions on the ports of the two-port gpio block
module gpio_monitor (
  input wire logic       ref_clk_i, rst_i, wr_i, rd_i, bus_hi_oe_i, bus_disable_o,
  input wire logic [3:0] addr_i,
  input wire logic [7:0] wdata_i, rdata_o, p1_periph_en_i, p1_periph_out_i, p1_periph_oe_i,
  input wire logic [7:0] p1_pad_i, p1_pad_o, p1_pad_oe_o, bus_hi_out_i, p2_pad_i, p2_pad_o, p2_pad_oe_o,
  input wire logic [7:0] bus_hi_in_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  wire mc = wr_i && addr_i == gpio_pkg::ADDR_MEM_CTL;
  property p_rd_idle; !rd_i |=> rdata_o == 8'h00; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
  property p_bd_wr; mc |=> bus_disable_o == $past(wdata_i[gpio_pkg::BUS_DIS_BIT]); endproperty
  a_bd_wr: assert property (p_bd_wr) else $error("bus disable not written");
  property p_bd_hold; !mc |=> $stable(bus_disable_o); endproperty
  a_bd_hold: assert property (p_bd_hold) else $error("bus disable changed");
  property p_bus_pad; !bus_disable_o |=> p2_pad_o == $past(bus_hi_out_i) && p2_pad_oe_o == {8{$past(bus_hi_oe_i)}};
  endproperty
  a_bus_pad: assert property (p_bus_pad) else $error("port 2 not on bus");
  property p_bus_in; !$past(rst_i) |-> bus_hi_in_o == $past(p2_pad_i); endproperty
  a_bus_in: assert property (p_bus_in) else $error("bus input wrong");
  property p_ovr; |p1_periph_en_i |=> (((p1_pad_oe_o ^ $past(p1_periph_oe_i)) |
    (p1_pad_o ^ $past(p1_periph_out_i))) & $past(p1_periph_en_i)) == 8'h00; endproperty
  a_ovr: assert property (p_ovr) else $error("override not honoured");
  property p_dir; wr_i && addr_i == gpio_pkg::ADDR_P1_DIR ##1 p1_periph_en_i == 8'h00
    |=> p1_pad_oe_o == ~$past(wdata_i, 2); endproperty
  a_dir: assert property (p_dir) else $error("drive enable wrong");
  property p_lat; wr_i && addr_i == gpio_pkg::ADDR_P1_LAT ##1 !wr_i && p1_periph_en_i == 8'h00
    |=> (p1_pad_o & p1_pad_oe_o) == ($past(wdata_i, 2) & p1_pad_oe_o); endproperty
  a_lat: assert property (p_lat) else $error("pin drive not latch");
  property p_pin_rd; rd_i && addr_i == gpio_pkg::ADDR_P1_PIN |=> rdata_o == $past(p1_pad_i, 2); endproperty
  a_pin_rd: assert property (p_pin_rd) else $error("pin read wrong");
  c_ovr: cover property (|p1_periph_en_i);
  c_gpio: cover property (bus_disable_o);
  c_pin: cover property (rd_i && addr_i == gpio_pkg::ADDR_P1_PIN);
endmodule : gpio_monitor

//--- tb/pad_net.sv
// pin net: a driven pin shows the drive, an undriven one the off-chip level
module pad_net (
  input  wire logic [7:0] drv_i, oe_i, ext_i,
  output logic      [7:0] lvl_o
);
  timeunit 1ns;
  timeprecision 1ns;
  assign lvl_o = (drv_i & oe_i) | (ext_i & ~oe_i);
endmodule : pad_net

//--- tb/tb.sv
// testbench for the two-port gpio block
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk_i = 1'b0, rst_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0, bus_hi_oe_i = 1'b0, bus_disable_o;
  logic [3:0] addr_i = 4'h0;
  logic [7:0] wdata_i = 8'h00, rdata_o, p1_periph_en_i = 8'h00, p1_periph_out_i = 8'h00, p1_periph_oe_i = 8'h00;
  logic [7:0] p2_periph_en_i = 8'h00, p2_periph_out_i = 8'h00, p2_periph_oe_i = 8'h00, bus_hi_out_i = 8'h00;
  logic [7:0] p1_pad_i, p1_pad_o, p1_pad_oe_o, p2_pad_i, p2_pad_o, p2_pad_oe_o, bus_hi_in_o, ext1 = 8'h00;
  int fails = 0, checked = 0, cyc = 0;
  bidir_port_pair_with_bus_mux i_bidir_port_pair_with_bus_mux (.*);
  pad_net i_pad_net_1 (.drv_i(p1_pad_o), .oe_i(p1_pad_oe_o), .ext_i(ext1), .lvl_o(p1_pad_i));
  pad_net i_pad_net_2 (.drv_i(p2_pad_o), .oe_i(p2_pad_oe_o), .ext_i(8'h3C), .lvl_o(p2_pad_i));
  initial forever #50 ref_clk_i = ~ref_clk_i;
  always @(posedge ref_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      fails++;
      complete_run();
    end
  end
  task automatic chk(input string n, input logic [7:0] e, g);
    checked++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge ref_clk_i) wr_i <= 1'b0;
    @(posedge ref_clk_i) #1;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [7:0] e, input string n);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge ref_clk_i) rd_i <= 1'b0;
    #1 chk(n, e, rdata_o);
    @(posedge ref_clk_i) #1;
  endtask : rd
  task automatic complete_run;
    $display("fails %0d checked %0d", fails, checked);
    if (fails == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : complete_run
  initial begin
    repeat (10) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    bus_hi_out_i <= 8'hA5;
    bus_hi_oe_i <= 1'b1;
    ext1 <= 8'hAA;
    @(posedge ref_clk_i) #1;
    rd(gpio_pkg::ADDR_MEM_CTL, 8'h00, "mem_ctl");
    rd(gpio_pkg::ADDR_P1_DIR, 8'hFF, "p1_dir");
    chk("bus_disable", 8'h00, {7'h00, bus_disable_o});
    chk("p2_pad_bus", 8'hA5, p2_pad_o);
    chk("p2_oe_bus", 8'hFF, p2_pad_oe_o);
    wr(gpio_pkg::ADDR_P1_DIR, 8'h0F);
    wr(gpio_pkg::ADDR_P1_LAT, 8'h3C);
    chk("p1_oe", 8'hF0, p1_pad_oe_o);
    chk("p1_out", 8'h30, p1_pad_o & 8'hF0);
    rd(gpio_pkg::ADDR_P1_LAT, 8'h3C, "p1_lat");
    rd(gpio_pkg::ADDR_P1_PIN, 8'h3A, "p1_pin");
    wr(gpio_pkg::ADDR_P1_PIN, 8'h55);
    rd(gpio_pkg::ADDR_P1_LAT, 8'h55, "p1_lat_pin");
    p1_periph_en_i <= 8'hFF;
    p1_periph_oe_i <= 8'h0F;
    p1_periph_out_i <= 8'hC3;
    rd(gpio_pkg::ADDR_P1_DIR, 8'h0F, "p1_dir_ovr");
    chk("p1_oe_ovr", 8'h0F, p1_pad_oe_o);
    chk("p1_out_ovr", 8'h03, p1_pad_o & 8'h0F);
    p1_periph_en_i <= 8'h00;
    wr(gpio_pkg::ADDR_P2_DIR, 8'h00);
    wr(gpio_pkg::ADDR_P2_LAT, 8'h99);
    chk("p2_pad_still_bus", 8'hA5, p2_pad_o);
    wr(gpio_pkg::ADDR_MEM_CTL, 8'hFF);
    chk("bus_disable_set", 8'h01, {7'h00, bus_disable_o});
    chk("p2_pad_gpio", 8'h99, p2_pad_o);
    rd(gpio_pkg::ADDR_MEM_CTL, 8'h80, "mem_ctl_rd");
    rd(gpio_pkg::ADDR_P2_PIN, 8'h99, "p2_pin");
    p2_periph_en_i <= 8'hFF;
    p2_periph_oe_i <= 8'hF0;
    p2_periph_out_i <= 8'h5A;
    rd(gpio_pkg::ADDR_P2_DIR, 8'h00, "p2_dir_ovr");
    chk("p2_oe_ovr", 8'hF0, p2_pad_oe_o);
    chk("p2_out_ovr", 8'h50, p2_pad_o & 8'hF0);
    p2_periph_en_i <= 8'h00;
    wr(4'h3, 8'hFF);
    rd(4'h3, 8'h00, "unmapped");
    wr(gpio_pkg::ADDR_MEM_CTL, 8'h00);
    chk("p2_pad_back", 8'hA5, p2_pad_o);
    bus_hi_oe_i <= 1'b0;
    rd(gpio_pkg::ADDR_P2_LAT, 8'h99, "p2_lat_bus");
    chk("p2_oe_bus_off", 8'h00, p2_pad_oe_o);
    rd(gpio_pkg::ADDR_P2_PIN, 8'h3C, "p2_pin_bus");
    chk("bus_hi_in", 8'h3C, bus_hi_in_o);
    complete_run();
  end
endmodule : tb
bind bidir_port_pair_with_bus_mux gpio_monitor i_gpio_monitor (.*);
